/* bench/crosspoint_program_control_tb.sv */
/*
  self-checking bench: host and device joined by the link, driven over Avalon-MM
  assumes: package, interface and both ends compiled first; checker instantiated here
*/
`timescale 1ns/100ps
module crosspoint_program_control_tb;
  logic                                       ref_clk;
  logic                                       nrst;
  logic                                       avs_read;
  logic                                       avs_write;
  logic                                       avs_waitrequest;
  logic [xpc_pkg::ADDR_W-1:0]                 avs_address;
  logic [31:0]                                avs_writedata;
  logic [31:0]                                avs_readdata;
  logic [31:0]                                rd;
  logic [31:0]                                lfsr;
  logic [31:0]                                exp_src;
  logic [31:0]                                keep_src;
  logic [7:0]                                 exp_en;
  logic [xpc_pkg::NUM_OUT*xpc_pkg::SRC_W-1:0] route_src;
  logic [xpc_pkg::NUM_OUT-1:0]                route_en;
  int                                         n_fail;
  int                                         n_compared;
  int                                         cyc;
  int                                         k;
  int                                         grp;
  int                                         enmask;
  int                                         out_src[8];
  int                                         out_en[8];

  xpc_if lnk();
  xpc_host u_xpc_host (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(lnk));
  xpc_device u_xpc_device (.lnk(lnk), .route_src(route_src), .route_en(route_en));
  xpc_sva u_xpc_sva (.ref_clk(ref_clk), .nrst(nrst), .link_clk(lnk.link_clk), .ce_n(lnk.ce_n),
    .update_n(lnk.update_n), .serial_parallel_select(lnk.serial_parallel_select), .data_in(lnk.data_in),
    .output_index(lnk.output_index), .xpt_reset_n(lnk.xpt_reset_n), .route_src(route_src),
    .route_en(route_en));

  // ==========================================================================
  // clock, timeout, helpers
  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("Error %0t timeout", $time);
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic av_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : av_wr

  task automatic av_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_rd

  task automatic wait_idle();
    do av_rd(xpc_pkg::REG_STATUS, rd); while (rd[xpc_pkg::STS_BUSY] !== 1'b0);
  endtask : wait_idle

  task automatic set_out(input int i, input logic [3:0] s, input logic e);
    out_src[i] = int'(s);
    out_en[i]  = int'(e);
    av_wr(xpc_pkg::REG_OUT0 + 6'(4 * i), {27'h0, e, s});
  endtask : set_out

  // reference model of the routing that the host must program
  task automatic model();
    int sz;
    int base;
    int s;
    sz = grp + 1;
    for (int i = 0; i < 8; i++) begin
      base = (i / sz) * sz;
      s = (out_src[base] / sz) * sz + (i - base);
      exp_src[4*i +: 4] = 4'(s);
      exp_en[i] = (out_en[base] != 0) && enmask[i] && (base + sz <= 8) && (s <= 15);
    end
  endtask : model

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_route();
    logic [31:0] m;
    for (int i = 0; i < 8; i++) m[4*i +: 4] = {4{exp_en[i]}};
    n_compared++;
    if (route_en !== exp_en || (route_src & m) !== (exp_src & m)) begin
      n_fail++;
      $display("Error %0t route en %h src %h expected %h %h", $time, route_en, route_src, exp_en, exp_src);
    end
  endtask : cmp_route

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // main sequence
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    lfsr = 32'h0A4E;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    cmp_word(32'(route_en), 32'h0);
    av_rd(xpc_pkg::REG_MODE, rd);
    cmp_word(rd, 32'h4);
    av_rd(xpc_pkg::REG_ENMASK, rd);
    cmp_word(rd, 32'hFF);
    av_rd(6'h3C, rd);
    cmp_word(rd, 32'h0);
    av_wr(xpc_pkg::REG_CMD, 32'h4);
    av_rd(xpc_pkg::REG_STATUS, rd);
    cmp_word(rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      grp = (i + 1) % 3;
      lfsr = lfsr_next(lfsr);
      enmask = (grp == 0) ? 255 : int'(lfsr[15:8]);
      av_wr(xpc_pkg::REG_ENMASK, 32'(enmask));
      av_wr(xpc_pkg::REG_MODE, 32'(grp));
      for (int j = 0; j < 8; j++) begin
        lfsr = lfsr_next(lfsr);
        set_out(j, (j == 1) ? 4'(out_src[0]) : lfsr[3:0], lfsr[4] | lfsr[5] | (j < 2));
      end
      av_wr(xpc_pkg::REG_CMD, 32'h5);
      wait_idle();
      cmp_word(rd, 32'h0000FF02);
      model();
      cmp_route();
      if (exp_en[7]) cmp_word(32'(lnk.data_out), 32'(exp_src[28]));
    end
    keep_src = route_src;
    for (int j = 0; j < 2; j++) begin
      lfsr = lfsr_next(lfsr);
      if (j == 0) k = int'(lfsr[2:0]);
      else k = k ^ 1;
      set_out(k, lfsr[6:3], 1'b1);
      av_wr(xpc_pkg::REG_CMD, 32'h2 | (32'(k) << 4));
      wait_idle();
    end
    cmp_word(route_src, keep_src);
    av_wr(xpc_pkg::REG_CMD, 32'h4);
    wait_idle();
    model();
    cmp_route();
    keep_src = route_src;
    av_wr(xpc_pkg::REG_MODE, 32'h4);
    repeat (2) @(posedge ref_clk);
    cmp_word(32'(route_en), 32'h0);
    cmp_word(route_src, keep_src);
    av_wr(xpc_pkg::REG_MODE, 32'h0);
    repeat (2) @(posedge ref_clk);
    cmp_word(32'(route_en), 32'h0);
    av_wr(xpc_pkg::REG_CMD, 32'h4);
    wait_idle();
    cmp_route();
    complete_run();
  end
endmodule : crosspoint_program_control_tb

/* bench/xpc_sva.sv */
/*
  assertions on the programming link and the route outputs of the crosspoint device
  assumes: instantiated by the bench beside the link interface; all link signals change on ref_clk
*/
`timescale 1ns/100ps
module xpc_sva (
  input wire logic                                       ref_clk,
  input wire logic                                       nrst,
  input wire logic                                       link_clk,
  input wire logic                                       ce_n,
  input wire logic                                       update_n,
  input wire logic                                       serial_parallel_select,
  input wire logic                                       data_in,
  input wire logic [xpc_pkg::IDX_W-1:0]                  output_index,
  input wire logic                                       xpt_reset_n,
  input wire logic [xpc_pkg::NUM_OUT*xpc_pkg::SRC_W-1:0] route_src,
  input wire logic [xpc_pkg::NUM_OUT-1:0]                route_en
);
  // ==========================================================================
  // helper logic: link clock falls, bits per frame, loaded state
  logic       lk_q;
  logic       loaded_q;
  logic [5:0] cnt_q;
  logic [7:0] pmask_q;
  wire        fall_w = lk_q & ~link_clk;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) lk_q <= 1'b1;
    else lk_q <= link_clk;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cnt_q <= 6'h00;
    else if (ce_n) cnt_q <= 6'h00;
    else if (fall_w && !serial_parallel_select) cnt_q <= cnt_q + 6'h01;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) pmask_q <= 8'h00;
    else if (fall_w && !ce_n && serial_parallel_select && update_n) pmask_q[output_index] <= 1'b1;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) loaded_q <= 1'b0;
    else if (cnt_q == 6'h28 || pmask_q == 8'hFF) loaded_q <= 1'b1;
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_rst_off;    !xpt_reset_n |-> route_en == 8'h00; endproperty
  property p_rst_keep;   $fell(xpt_reset_n) |-> route_src === $past(route_src); endproperty
  property p_hold;       update_n && $past(update_n) |-> route_src === $past(route_src); endproperty
  property p_upd_ce;     !update_n |-> !ce_n; endproperty
  property p_upd_len;    $fell(update_n) |-> !update_n [*6] ##1 update_n; endproperty
  property p_upd_loaded; $fell(update_n) |-> loaded_q; endproperty
  property p_frame_len;  $rose(ce_n) |-> cnt_q == 6'h00 || cnt_q == 6'h28; endproperty
  property p_data_hold;  fall_w |-> $stable(data_in); endproperty
  property p_idle_clk;   ce_n |-> link_clk; endproperty
  property p_par_upd;    fall_w && serial_parallel_select |-> update_n; endproperty
  property p_mode_hold;  !ce_n && !$past(ce_n) |-> $stable(serial_parallel_select); endproperty

  a_rst_off:    assert property (p_rst_off)    else $error("outputs enabled in reset");
  a_rst_keep:   assert property (p_rst_keep)   else $error("reset changed sources");
  a_hold:       assert property (p_hold)       else $error("route moved without update");
  a_upd_ce:     assert property (p_upd_ce)     else $error("update without select");
  a_upd_len:    assert property (p_upd_len)    else $error("update pulse length wrong");
  a_upd_loaded: assert property (p_upd_loaded) else $error("update before load");
  a_frame_len:  assert property (p_frame_len)  else $error("serial frame not 40 bits");
  a_data_hold:  assert property (p_data_hold)  else $error("data moved at falling edge");
  a_idle_clk:   assert property (p_idle_clk)   else $error("link clock not idle high");
  a_par_upd:    assert property (p_par_upd)    else $error("parallel latch with update low");
  a_mode_hold:  assert property (p_mode_hold)  else $error("mode pin moved in frame");

  c_serial:  cover property ($fell(update_n) && !serial_parallel_select);
  c_par:     cover property (fall_w && serial_parallel_select);
  c_reset:   cover property ($fell(xpt_reset_n));
endmodule : xpc_sva

/* hw/xpc_device.sv */
/*
  crosspoint device end: shift register, update latches and output enables
  assumes: link_clk comes from the host; data and strobes are set up while link_clk is high
*/
`timescale 1ns/100ps

module xpc_device (
  xpc_if.device                                  lnk,
  output logic [xpc_pkg::NUM_OUT*xpc_pkg::SRC_W-1:0] route_src,
  output logic [xpc_pkg::NUM_OUT-1:0]               route_en
);

  // ==========================================================================
  // shift register
  logic [xpc_pkg::FRAME_W-1:0] shift_q;
  logic [xpc_pkg::FRAME_W-1:0] shift_d;
  logic [xpc_pkg::GRP_W-1:0]   par_grp;
  logic                        do_serial;
  logic                        do_parallel;

  assign do_serial   = !lnk.ce_n && !lnk.serial_parallel_select;
  assign do_parallel = !lnk.ce_n && lnk.serial_parallel_select && lnk.update_n;
  assign par_grp     = xpc_pkg::xpc_pack(lnk.source_select, lnk.output_enable_bit);

  always_comb begin
    shift_d = shift_q;
    if (do_serial) begin
      shift_d = {shift_q[xpc_pkg::FRAME_W-2:0], lnk.data_in};
    end else if (do_parallel) begin
      shift_d[lnk.output_index*xpc_pkg::GRP_W +: xpc_pkg::GRP_W] = par_grp;
    end
  end

  // no reset: contents stay unknown until loaded
  always_ff @(negedge lnk.link_clk) begin
    shift_q <= shift_d;
  end

  assign lnk.data_out = shift_q[xpc_pkg::FRAME_W-1];

  // ==========================================================================
  // update latches
  logic                                         strobe_open;
  logic [xpc_pkg::NUM_OUT*xpc_pkg::SRC_W-1:0]   src_lat;
  logic [xpc_pkg::NUM_OUT-1:0]                  en_lat;
  logic [xpc_pkg::NUM_OUT*xpc_pkg::SRC_W-1:0]   src_from_shift;
  logic [xpc_pkg::NUM_OUT-1:0]                  en_from_shift;

  assign strobe_open = !lnk.update_n && !lnk.ce_n;

  for (genvar k = 0; k < xpc_pkg::NUM_OUT; k++) begin : g_unpack
    assign src_from_shift[k*xpc_pkg::SRC_W +: xpc_pkg::SRC_W] =
      xpc_pkg::xpc_src(shift_q[k*xpc_pkg::GRP_W +: xpc_pkg::GRP_W]);
    assign en_from_shift[k] = xpc_pkg::xpc_en(shift_q[k*xpc_pkg::GRP_W +: xpc_pkg::GRP_W]);
  end

  // selections are never touched by reset
  always_latch begin
    if (strobe_open) begin
      src_lat = src_from_shift;
    end
  end

  // enables are forced off while reset is low
  always_latch begin
    if (!lnk.xpt_reset_n) begin
      en_lat = '0;
    end else if (strobe_open) begin
      en_lat = en_from_shift;
    end
  end

  // ==========================================================================
  // matrix drive
  assign route_src = src_lat;
  assign route_en  = en_lat & {xpc_pkg::NUM_OUT{lnk.xpt_reset_n}};

endmodule : xpc_device

/* hw/xpc_host.sv */
/*
  host controller end: Avalon-MM register slave and programming sequencer
  assumes: ref_clk at 250 MHz; the link clock is made here by division
*/
`timescale 1ns/100ps
module xpc_host (
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  input  wire logic [xpc_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  xpc_if.host                              lnk
);

  localparam int NO = xpc_pkg::NUM_OUT;
  localparam int SW = xpc_pkg::SRC_W;
  localparam int GW = xpc_pkg::GRP_W;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_CLK_LO, ST_CLK_HI, ST_UPD, ST_END} xpc_st_e;

  // ==========================================================================
  // grouping map for pairs and triples
  function automatic logic [GW-1:0] map_group(input int k, input logic [1:0] mode,
                                              input logic [NO*SW-1:0] src_all, input logic [NO-1:0] en_all);
    int         g;
    int         base;
    int         sv;
    logic       en;
    logic [3:0] bsrc;
    g = (mode == xpc_pkg::XPC_GRP_PAIR) ? 2 : (mode == xpc_pkg::XPC_GRP_TRIPLE) ? 3 : 1;
    base = k - (k % g);
    bsrc = src_all[base*SW +: SW];
    sv   = int'(bsrc) - (int'(bsrc) % g) + (k - base);
    en   = en_all[base] && (base + g <= NO) && (sv < xpc_pkg::NUM_IN);
    return {sv[SW-1:0], en};
  endfunction : map_group

  // ==========================================================================
  // registers
  logic [NO*SW-1:0]  out_src_q;
  logic [NO-1:0]     out_en_q;
  logic [1:0]        grp_q;
  logic              hold_q;
  logic [NO-1:0]     en_mask_q;
  logic [NO-1:0]     written_q;
  logic              loaded_q;
  logic              ack_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;

  logic              wr_fire;
  logic              is_out;
  logic [2:0]        out_k;
  logic              busy;
  logic              cmd_ser;
  logic              cmd_par;
  logic              cmd_upd;
  logic              cmd_go;

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_fire  = avs_write && ack_q;
  assign is_out   = avs_address >= xpc_pkg::REG_OUT0 && avs_address < xpc_pkg::REG_OUTEND;
  assign out_k    = 3'((avs_address - xpc_pkg::REG_OUT0) >> 2);
  assign cmd_go   = wr_fire && avs_address == xpc_pkg::REG_CMD && !busy;
  assign cmd_ser  = cmd_go && avs_writedata[xpc_pkg::CMD_SERIAL];
  assign cmd_par  = cmd_go && avs_writedata[xpc_pkg::CMD_PARALLEL] && !avs_writedata[xpc_pkg::CMD_SERIAL];
  assign cmd_upd  = cmd_go && avs_writedata[xpc_pkg::CMD_UPDATE];
  assign avs_readdata = rdata_q;

  always_comb begin
    rdata_d = 32'h0;
    if (avs_address == xpc_pkg::REG_STATUS) begin
      rdata_d[xpc_pkg::STS_BUSY]   = busy;
      rdata_d[xpc_pkg::STS_LOADED] = loaded_q;
      rdata_d[xpc_pkg::STS_WR_LSB +: NO] = written_q;
    end else if (avs_address == xpc_pkg::REG_MODE) begin
      rdata_d[xpc_pkg::MODE_GRP_LSB +: 2] = grp_q;
      rdata_d[xpc_pkg::MODE_HOLD] = hold_q;
    end else if (avs_address == xpc_pkg::REG_ENMASK) begin
      rdata_d[NO-1:0] = en_mask_q;
    end else if (is_out) begin
      rdata_d[SW-1:0] = out_src_q[out_k*SW +: SW];
      rdata_d[xpc_pkg::OUT_EN_POS] = out_en_q[out_k];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0;
      out_src_q <= '0;
      out_en_q  <= '0;
      grp_q     <= xpc_pkg::MODE_GRP_RST;
      hold_q    <= 1'b1;
      en_mask_q <= xpc_pkg::ENMASK_RST;
    end else begin
      ack_q   <= (avs_read || avs_write) && !ack_q;
      rdata_q <= rdata_d;
      if (wr_fire && avs_address == xpc_pkg::REG_MODE) begin
        grp_q  <= avs_writedata[xpc_pkg::MODE_GRP_LSB +: 2];
        hold_q <= avs_writedata[xpc_pkg::MODE_HOLD];
      end
      if (wr_fire && avs_address == xpc_pkg::REG_ENMASK) begin
        en_mask_q <= avs_writedata[NO-1:0];
      end
      if (wr_fire && is_out) begin
        out_src_q[out_k*SW +: SW] <= avs_writedata[SW-1:0];
        out_en_q[out_k]           <= avs_writedata[xpc_pkg::OUT_EN_POS];
      end
    end
  end

  // ==========================================================================
  // effective frame after grouping and wired-group mask
  logic [xpc_pkg::FRAME_W-1:0] frame_w;

  for (genvar k = 0; k < NO; k++) begin : g_frame
    logic [GW-1:0] m;
    assign m = map_group(k, grp_q, out_src_q, out_en_q);
    assign frame_w[k*GW +: GW] = xpc_pkg::xpc_pack(m[GW-1:1], m[0] && en_mask_q[k]);
  end

  // ==========================================================================
  // sequencer
  xpc_st_e                      st_q;
  logic [xpc_pkg::TMR_W-1:0]    tmr_q;
  logic [xpc_pkg::BIT_W-1:0]    bit_q;
  logic [xpc_pkg::FRAME_W-1:0]  frame_q;
  logic                         par_q;
  logic                         upd_q;
  logic [2:0]                   idx_q;
  logic                         tmr_done;
  logic [2:0]                   cmd_idx;
  logic [GW-1:0]                par_grp;
  logic                         pass_done;

  assign busy      = st_q != ST_IDLE;
  assign tmr_done  = tmr_q == '0;
  assign cmd_idx   = avs_writedata[xpc_pkg::CMD_IDX_LSB +: 3];
  assign par_grp   = frame_w[cmd_idx*GW +: GW];
  assign pass_done = par_q || bit_q == 6'(xpc_pkg::FRAME_W);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q      <= ST_IDLE;
      tmr_q     <= '0;
      bit_q     <= '0;
      frame_q   <= '0;
      par_q     <= 1'b0;
      upd_q     <= 1'b0;
      idx_q     <= '0;
      written_q <= '0;
      loaded_q  <= 1'b0;
      lnk.link_clk               <= 1'b1;
      lnk.ce_n                   <= 1'b1;
      lnk.update_n               <= 1'b1;
      lnk.serial_parallel_select <= 1'b0;
      lnk.data_in                <= 1'b0;
      lnk.output_index           <= '0;
      lnk.source_select          <= '0;
      lnk.output_enable_bit      <= 1'b0;
      lnk.xpt_reset_n            <= 1'b0;
    end else begin
      lnk.xpt_reset_n <= !hold_q;
      if (!tmr_done) begin
        tmr_q <= tmr_q - 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          if (cmd_ser || cmd_par) begin
            st_q    <= ST_SETUP;
            tmr_q   <= xpc_pkg::TMR_W'(xpc_pkg::LINK_HALF_CYC);
            bit_q   <= '0;
            par_q   <= cmd_par;
            upd_q   <= cmd_upd;
            idx_q   <= cmd_idx;
            frame_q <= frame_w;
            lnk.ce_n                   <= 1'b0;
            lnk.update_n               <= 1'b1;
            lnk.serial_parallel_select <= cmd_par;
            lnk.data_in                <= frame_w[xpc_pkg::FRAME_W-1];
            lnk.output_index           <= cmd_idx;
            lnk.source_select          <= xpc_pkg::xpc_src(par_grp);
            lnk.output_enable_bit      <= xpc_pkg::xpc_en(par_grp);
          end else if (cmd_upd && loaded_q) begin
            st_q         <= ST_UPD;
            tmr_q        <= xpc_pkg::TMR_W'(xpc_pkg::UPDATE_LOW_CYC);
            lnk.ce_n     <= 1'b0;
            lnk.update_n <= 1'b0;
          end
        end
        ST_SETUP: begin
          if (tmr_done) begin
            st_q         <= ST_CLK_LO;
            tmr_q        <= xpc_pkg::TMR_W'(xpc_pkg::LINK_HALF_CYC);
            lnk.link_clk <= 1'b0;
          end
        end
        ST_CLK_LO: begin
          if (tmr_done) begin
            st_q         <= ST_CLK_HI;
            tmr_q        <= xpc_pkg::TMR_W'(xpc_pkg::LINK_HALF_CYC);
            lnk.link_clk <= 1'b1;
            bit_q        <= bit_q + 1'b1;
            frame_q      <= {frame_q[xpc_pkg::FRAME_W-2:0], 1'b0};
            lnk.data_in  <= frame_q[xpc_pkg::FRAME_W-2];
          end
        end
        ST_CLK_HI: begin
          if (tmr_done && !pass_done) begin
            st_q         <= ST_CLK_LO;
            tmr_q        <= xpc_pkg::TMR_W'(xpc_pkg::LINK_HALF_CYC);
            lnk.link_clk <= 1'b0;
          end else if (tmr_done) begin
            if (par_q) begin
              written_q[idx_q] <= 1'b1;
              loaded_q         <= &(written_q | (8'h01 << idx_q));
            end else begin
              written_q <= '1;
              loaded_q  <= 1'b1;
            end
            if (upd_q && (!par_q || &(written_q | (8'h01 << idx_q)))) begin
              st_q         <= ST_UPD;
              tmr_q        <= xpc_pkg::TMR_W'(xpc_pkg::UPDATE_LOW_CYC);
              lnk.update_n <= 1'b0;
            end else begin
              st_q <= ST_END;
            end
          end
        end
        ST_UPD: begin
          if (tmr_done) begin
            st_q         <= ST_END;
            lnk.update_n <= 1'b1;
          end
        end
        ST_END: begin
          st_q     <= ST_IDLE;
          lnk.ce_n <= 1'b1;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : xpc_host

/* hw/xpc_if.sv */
/*
  programming link between the host controller and the crosspoint device
  assumes: the host drives every signal but data_out; the device drives data_out
*/
`timescale 1ns/100ps
interface xpc_if;
  logic                       link_clk;
  logic                       ce_n;
  logic                       update_n;
  logic                       serial_parallel_select;
  logic                       data_in;
  logic                       data_out;
  logic [xpc_pkg::IDX_W-1:0]  output_index;
  logic [xpc_pkg::SRC_W-1:0]  source_select;
  logic                       output_enable_bit;
  logic                       xpt_reset_n;

  modport host (
    output link_clk,
    output ce_n,
    output update_n,
    output serial_parallel_select,
    output data_in,
    output output_index,
    output source_select,
    output output_enable_bit,
    output xpt_reset_n,
    input  data_out
  );

  modport device (
    input  link_clk,
    input  ce_n,
    input  update_n,
    input  serial_parallel_select,
    input  data_in,
    input  output_index,
    input  source_select,
    input  output_enable_bit,
    input  xpt_reset_n,
    output data_out
  );
endinterface : xpc_if

/* hw/xpc_pkg.sv */
/*
  shared constants, types and field helpers for the crosspoint program control
  assumes: both ends and the interface compile after this package
*/
package xpc_pkg;

  // ==========================================================================
  // matrix shape
  localparam int NUM_OUT = 8;
  localparam int NUM_IN  = 16;
  localparam int SRC_W   = 4;
  localparam int GRP_W   = 5;
  localparam int IDX_W   = 3;
  localparam int FRAME_W = NUM_OUT * GRP_W;
  localparam int BIT_W   = 6;

  // position of the enable bit and of the topmost source bit inside a five-bit group
  localparam int GRP_EN_POS  = 0;
  localparam int GRP_SRC_TOP = 4;

  // ==========================================================================
  // host register map (byte addresses)
  localparam int          ADDR_W     = 6;
  localparam logic [5:0]  REG_CMD    = 6'h00;
  localparam logic [5:0]  REG_STATUS = 6'h04;
  localparam logic [5:0]  REG_MODE   = 6'h08;
  localparam logic [5:0]  REG_ENMASK = 6'h0C;
  localparam logic [5:0]  REG_OUT0   = 6'h10;
  localparam logic [5:0]  REG_OUTEND = 6'h30;

  // command bits
  localparam int CMD_SERIAL   = 0;
  localparam int CMD_PARALLEL = 1;
  localparam int CMD_UPDATE   = 2;
  localparam int CMD_IDX_LSB  = 4;

  // status bits
  localparam int STS_BUSY   = 0;
  localparam int STS_LOADED = 1;
  localparam int STS_WR_LSB = 8;

  // mode bits
  localparam int MODE_GRP_LSB = 0;
  localparam int MODE_HOLD    = 2;

  // out_k fields
  localparam int OUT_EN_POS = 4;

  // reset values
  localparam logic [1:0]         MODE_GRP_RST = 2'h0;
  localparam logic [NUM_OUT-1:0] ENMASK_RST   = 8'hFF;

  typedef enum logic [1:0] {
    XPC_GRP_SINGLE,
    XPC_GRP_PAIR,
    XPC_GRP_TRIPLE
  } xpc_grp_e;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int LINK_HALF_NS   = 12;
  localparam int UPDATE_LOW_NS  = 20;
  localparam int LINK_HALF_CYC  = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPDATE_LOW_CYC = (UPDATE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W          = 4;

  // ==========================================================================
  // group packing: first bit sent is source bit 0, the enable bit comes last
  function automatic logic [GRP_W-1:0] xpc_pack(input logic [SRC_W-1:0] src, input logic en);
    return {src[0], src[1], src[2], src[3], en};
  endfunction : xpc_pack

  function automatic logic [SRC_W-1:0] xpc_src(input logic [GRP_W-1:0] grp);
    return {grp[1], grp[2], grp[3], grp[GRP_SRC_TOP]};
  endfunction : xpc_src

  function automatic logic xpc_en(input logic [GRP_W-1:0] grp);
    return grp[GRP_EN_POS];
  endfunction : xpc_en

endpackage : xpc_pkg
